// >>> src/adc_seq_pkg.sv
// Purpose: Constants and types shared by the converter sequencing block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses; field positions are bit indices.
//
// Overview of operation
// - Setting sample request starts acquisition; clearing it manually starts conversion.
// - Automatic mode: hardware starts acquisition, selected trigger ends it.
// - Acquisition length comes from sample-time field, control 3 bits 12:8.
// - Conversion lasts one clock period per bit plus two: twelve periods.
// - Each finished result goes into one of sixteen buffer words.
// - Conversion clock source bit 15, divided by prescaler bits 7:0 plus one.
// - Auto-sample restarts acquisition at end of every conversion.
// - Trigger source field bits 7:5; a firing trigger ends sampling.
// - Auto-convert trigger fires after sample-time count of conversion periods.
// - Auto-sample plus auto-convert runs conversions endlessly without software.
// - Interrupt flag rises after sequences-per-interrupt field plus one results.
// - Each new sequence refills the buffer from word 0; in split mode, sequences alternate between word 0 and word 8.
// - Alternate-mux bit toggles between mux A and mux B settings.
// - Scan enable steps mux A through selected analog inputs.
// - Buffer fill mode bit selects one sixteen-word or two eight-word halves.
// - Result format field bits 10:8 shapes every read result.
// - Reference field bits 15:13 selects the voltage reference.
// - Pin config bit 0 makes pin analog, disabling its digital buffer.
// - Pin config register clears on reset, all pins analog.
// - Digital port read returns zero for analog-configured pins.
// - Negative input picks reference or input one; positive uses five bits.
// - Scan mode overrides mux A positive selection.
// - Scan select bit one includes the input, zero skips it.
// - Signed formats extend over 32 bits or only the lower 16.

package adc_seq_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CTRL3  = 8'h08;
  localparam logic [7:0] OFS_MUXSEL = 8'h0C;
  localparam logic [7:0] OFS_PINCFG = 8'h10;
  localparam logic [7:0] OFS_SCAN   = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_BUF0   = 8'h40;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int C1_ON    = 15;
  localparam int C1_FMT   = 8;
  localparam int C1_TRIG  = 5;
  localparam int C1_AUTO_SAMPLE_ENABLE  = 2;
  localparam int C1_SAMPLE_REQUEST_BIT  = 1;
  localparam int C1_DONE  = 0;
  localparam int C2_REF   = 13;
  localparam int C2_SCAN  = 10;
  localparam int C2_SEQUENCES_PER_INTERRUPT  = 2;
  localparam int C2_BUFFER_FILL_MODE  = 1;
  localparam int C2_ALTERNATE_MUX_ENABLE  = 0;
  localparam int C3_SRC   = 15;
  localparam int C3_SAMPLE_TIME_COUNT  = 8;
  localparam int C3_PRE   = 0;
  localparam int MX_NB    = 31;
  localparam int MX_PB    = 24;
  localparam int MX_NA    = 23;
  localparam int MX_PA    = 16;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam int          CONV_PERIODS = 12;
  localparam int          RESULT_BITS  = 10;

  // Trigger sources.
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_EXT    = 3'h1;
  localparam logic [2:0] TRIG_AUTO   = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11
  } seq_state_t;

endpackage

// >>> src/adc_seq_ctrl.sv
// Purpose: Sequencing, register file and result buffer for a 10-bit SAR converter.
// Assumes: The analog core converts while conv_busy is high and returns its
//          result on core_result before the period count ends.
// Notes:   The alternate conversion clock is a second input sampled into pclk.
`timescale 1ns/1ps

module adc_seq_ctrl #(
  parameter int NUM_INPUTS = 16,
  parameter int BUF_DEPTH  = 16
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Triggers and clock sources
  input  wire logic        ext_trigger,
  input  wire logic        alt_clock_tick,
  // Analog side
  output logic             sample_connect,
  output logic             conv_busy,
  output logic [4:0]       mux_positive,
  output logic             mux_negative,
  output logic [2:0]       reference_select,
  input  wire logic [9:0]  core_result,
  // Pins and port
  input  wire logic [NUM_INPUTS-1:0] pin_in,
  output logic [NUM_INPUTS-1:0]      pin_digital_enable,
  output logic [NUM_INPUTS-1:0]      port_read,
  // Events
  output logic             converter_interrupt_flag
);

  // ****************************************************************
  // Registers and synchronisers
  // ****************************************************************
  logic [31:0] ctrl1_r, ctrl2_r, ctrl3_r, muxsel_r, pincfg_r, scan_r;
  logic [9:0]  buf_r [BUF_DEPTH];
  logic [3:0]  wr_idx_r;
  logic [4:0]  seq_cnt_r;
  logic        half_r;
  logic        alt_r;
  logic [3:0]  scan_idx_r;
  logic [7:0]  pre_cnt_r;
  logic [4:0]  per_cnt_r;
  logic [1:0]  ext_sync_r, alt_sync_r;
  logic        ext_prev_r, alt_prev_r;
  logic [NUM_INPUTS-1:0] pin_s1_r, pin_s2_r;
  adc_seq_pkg::seq_state_t state_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_r <= 2'h0;
      alt_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
      alt_prev_r <= 1'b0;
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], ext_trigger};
      alt_sync_r <= {alt_sync_r[0], alt_clock_tick};
      ext_prev_r <= ext_sync_r[1];
      alt_prev_r <= alt_sync_r[1];
      pin_s1_r   <= pin_in;
      pin_s2_r   <= pin_s1_r;
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  logic src_tick, tad_tick;
  assign src_tick = ctrl3_r[adc_seq_pkg::C3_SRC] ? (alt_sync_r[1] & ~alt_prev_r) : 1'b1;
  // One period lasts prescaler+1 source ticks.
  assign tad_tick = src_tick && (pre_cnt_r == ctrl3_r[adc_seq_pkg::C3_PRE +: 8]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (state_r == adc_seq_pkg::ST_IDLE) begin
      pre_cnt_r <= 8'h00;
    end else if (src_tick) begin
      pre_cnt_r <= tad_tick ? 8'h00 : pre_cnt_r + 8'h01;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic       on_w, auto_sample_enable_w, manual_w, trig_fire, conv_end, apb_wr, seq_wrap;
  logic [2:0] trig_w;
  logic [3:0] sequences_per_interrupt_w;
  assign on_w     = ctrl1_r[adc_seq_pkg::C1_ON];
  assign auto_sample_enable_w   = ctrl1_r[adc_seq_pkg::C1_AUTO_SAMPLE_ENABLE];
  assign trig_w   = ctrl1_r[adc_seq_pkg::C1_TRIG +: 3];
  assign sequences_per_interrupt_w   = ctrl2_r[adc_seq_pkg::C2_SEQUENCES_PER_INTERRUPT +: 4];
  assign manual_w = (trig_w == adc_seq_pkg::TRIG_MANUAL);
  assign apb_wr   = psel & penable & pwrite;

  // Manual ending is the request bit going low while sampling.
  always_comb begin
    unique case (trig_w)
      adc_seq_pkg::TRIG_MANUAL: trig_fire = ~ctrl1_r[adc_seq_pkg::C1_SAMPLE_REQUEST_BIT];
      adc_seq_pkg::TRIG_EXT:    trig_fire = ext_sync_r[1] & ~ext_prev_r;
      adc_seq_pkg::TRIG_AUTO:   trig_fire = tad_tick &&
          (per_cnt_r >= ctrl3_r[adc_seq_pkg::C3_SAMPLE_TIME_COUNT +: 5]);
      default:                  trig_fire = 1'b0;
    endcase
  end
  assign conv_end = (state_r == adc_seq_pkg::ST_CONV) && tad_tick &&
                    (per_cnt_r == 5'(adc_seq_pkg::CONV_PERIODS - 1));
  assign seq_wrap = (seq_cnt_r == {1'b0, sequences_per_interrupt_w});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= adc_seq_pkg::ST_IDLE;
      per_cnt_r <= 5'h00;
    end else if (!on_w) begin
      state_r   <= adc_seq_pkg::ST_IDLE;
      per_cnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        adc_seq_pkg::ST_IDLE: begin
          per_cnt_r <= 5'h00;
          if (ctrl1_r[adc_seq_pkg::C1_SAMPLE_REQUEST_BIT] || auto_sample_enable_w) begin
            state_r <= adc_seq_pkg::ST_SAMPLE;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          if (trig_fire) begin
            state_r   <= adc_seq_pkg::ST_CONV;
            per_cnt_r <= 5'h00;
          end else if (tad_tick && per_cnt_r != 5'h1F) begin
            per_cnt_r <= per_cnt_r + 5'h01;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (conv_end) begin
            per_cnt_r <= 5'h00;
            // Auto-sample reconnects at once, giving free-running operation.
            state_r   <= auto_sample_enable_w ? adc_seq_pkg::ST_SAMPLE
                                : adc_seq_pkg::ST_IDLE;
          end else if (tad_tick) begin
            per_cnt_r <= per_cnt_r + 5'h01;
          end
        end
        default: state_r <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Input selection
  // ****************************************************************
  function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [31:0] sel);
    logic [3:0] n;
    n = cur;
    for (int i = 1; i <= 16; i++) begin
      if (sel[4'(cur + 4'(i))] && n == cur) begin
        n = 4'(cur + 4'(i));
      end
    end
    return n;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r      <= 1'b0;
      scan_idx_r <= 4'h0;
    end else if (state_r == adc_seq_pkg::ST_IDLE && !on_w) begin
      alt_r      <= 1'b0;
      scan_idx_r <= next_scan(4'hF, scan_r);
    end else if (conv_end) begin
      alt_r      <= ctrl2_r[adc_seq_pkg::C2_ALTERNATE_MUX_ENABLE] & ~alt_r;
      if (!alt_r) begin
        scan_idx_r <= next_scan(scan_idx_r, scan_r);
      end
    end
  end

  always_comb begin
    if (alt_r) begin
      mux_positive = muxsel_r[adc_seq_pkg::MX_PB +: 5];
      mux_negative = muxsel_r[adc_seq_pkg::MX_NB];
    end else begin
      mux_positive = ctrl2_r[adc_seq_pkg::C2_SCAN] ? {1'b0, scan_idx_r}
                                                   : muxsel_r[adc_seq_pkg::MX_PA +: 5];
      mux_negative = muxsel_r[adc_seq_pkg::MX_NA];
    end
  end

  assign sample_connect   = (state_r == adc_seq_pkg::ST_SAMPLE);
  assign conv_busy        = (state_r == adc_seq_pkg::ST_CONV);
  assign reference_select = ctrl2_r[adc_seq_pkg::C2_REF +: 3];
  assign pin_digital_enable = pincfg_r[NUM_INPUTS-1:0];
  assign port_read          = pin_s2_r & pincfg_r[NUM_INPUTS-1:0];

  // ****************************************************************
  // Result buffer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_idx_r  <= 4'h0;
      seq_cnt_r <= 5'h00;
      half_r    <= 1'b0;
    end else if (!on_w) begin
      wr_idx_r  <= 4'h0;
      seq_cnt_r <= 5'h00;
      half_r    <= 1'b0;
    end else if (conv_end) begin
      if (seq_wrap) begin
        seq_cnt_r <= 5'h00;
        // Split mode flips halves each sequence; otherwise restart at word 0.
        half_r    <= ctrl2_r[adc_seq_pkg::C2_BUFFER_FILL_MODE] & ~half_r;
        wr_idx_r  <= (ctrl2_r[adc_seq_pkg::C2_BUFFER_FILL_MODE] & ~half_r) ? 4'h8 : 4'h0;
      end else begin
        seq_cnt_r <= seq_cnt_r + 5'h01;
        wr_idx_r  <= wr_idx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_r[i] <= 10'h000;
      end
    end else if (conv_end) begin
      buf_r[wr_idx_r] <= core_result;
    end
  end

  // Flag set wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_interrupt_flag <= 1'b0;
    end else if (conv_end && seq_wrap) begin
      converter_interrupt_flag <= 1'b1;
    end else if (apb_wr && paddr == adc_seq_pkg::OFS_STATUS && pwdata[0]) begin
      converter_interrupt_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Result formatting
  // ****************************************************************
  function automatic logic [31:0] fmt_result(input logic [9:0] d, input logic [2:0] f);
    logic [9:0]  s;
    logic [31:0] r;
    s = d ^ 10'h200;
    unique case (f)
      3'h0: r = {22'h0, d};
      3'h1: r = {16'h0, {6{s[9]}}, s};
      3'h2: r = {16'h0, d, 6'h00};
      3'h3: r = {16'h0, s, 6'h00};
      3'h4: r = {22'h0, d};
      3'h5: r = {{22{s[9]}}, s};
      3'h6: r = {d, 22'h0};
      default: r = {s, 22'h0};
    endcase
    return r;
  endfunction

  // ****************************************************************
  // APB register file
  // ****************************************************************
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r  <= adc_seq_pkg::RST_ZERO;
      ctrl2_r  <= adc_seq_pkg::RST_ZERO;
      ctrl3_r  <= adc_seq_pkg::RST_ZERO;
      muxsel_r <= adc_seq_pkg::RST_ZERO;
      pincfg_r <= adc_seq_pkg::RST_ZERO;
      scan_r   <= adc_seq_pkg::RST_ZERO;
    end else begin
      if (apb_wr) begin
        unique case (paddr)
          adc_seq_pkg::OFS_CTRL1:  ctrl1_r  <= {16'h0, pwdata[15:1], 1'b0};
          adc_seq_pkg::OFS_CTRL2:  ctrl2_r  <= {16'h0, pwdata[15:0]};
          adc_seq_pkg::OFS_CTRL3:  ctrl3_r  <= {16'h0, pwdata[15:0]};
          adc_seq_pkg::OFS_MUXSEL: muxsel_r <= pwdata;
          adc_seq_pkg::OFS_PINCFG: pincfg_r <= {16'h0, pwdata[15:0]};
          adc_seq_pkg::OFS_SCAN:   scan_r   <= {16'h0, pwdata[15:0]};
          default: ;
        endcase
      end
      if (state_r == adc_seq_pkg::ST_SAMPLE && trig_fire && !manual_w) begin
        ctrl1_r[adc_seq_pkg::C1_SAMPLE_REQUEST_BIT] <= 1'b0;
      end
      if (state_r == adc_seq_pkg::ST_CONV && !auto_sample_enable_w && conv_end) begin
        ctrl1_r[adc_seq_pkg::C1_DONE] <= 1'b1;
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr >= adc_seq_pkg::OFS_BUF0) begin
      if (paddr < 8'(adc_seq_pkg::OFS_BUF0 + 8'(4 * BUF_DEPTH))) begin
        prdata = fmt_result(buf_r[4'(paddr[7:2])], ctrl1_r[adc_seq_pkg::C1_FMT +: 3]);
      end
    end else begin
      unique case (paddr)
        adc_seq_pkg::OFS_CTRL1:  prdata = ctrl1_r;
        adc_seq_pkg::OFS_CTRL2:  prdata = ctrl2_r;
        adc_seq_pkg::OFS_CTRL3:  prdata = ctrl3_r;
        adc_seq_pkg::OFS_MUXSEL: prdata = muxsel_r;
        adc_seq_pkg::OFS_PINCFG: prdata = pincfg_r;
        adc_seq_pkg::OFS_SCAN:   prdata = scan_r;
        adc_seq_pkg::OFS_STATUS: prdata = {24'h0, half_r, alt_r, state_r, 3'h0,
                                           converter_interrupt_flag};
        default:                 prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conv_busy) |-> conv_busy [*8]) else $error("conversion ended too early");
  trig_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_connect && trig_fire && on_w) |=> conv_busy) else $error("trigger ignored");
  auto_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_end && auto_sample_enable_w && on_w) |=> sample_connect) else $error("no auto resample");
  sample_request_bit_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_connect && trig_fire && !manual_w && on_w) |=> !ctrl1_r[1])
    else $error("request not cleared");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_end && seq_wrap && on_w) |=> converter_interrupt_flag) else $error("flag missing");
  buf_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_end && seq_wrap && on_w && !ctrl2_r[1]) |=> wr_idx_r == 4'h0)
    else $error("buffer not restarted");
  port_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (port_read & ~pincfg_r[NUM_INPUTS-1:0]) == '0) else $error("analog pin reads one");
  buf_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end |=> buf_r[$past(wr_idx_r)] == $past(core_result)) else $error("result lost");
  alt_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_end && on_w && !ctrl2_r[0]) |=> !alt_r) else $error("mux B used");
  conv_cov_c: cover property (@(posedge pclk) conv_end);
  wrap_cov_c: cover property (@(posedge pclk) conv_end && seq_wrap);
  auto_cov_c: cover property (@(posedge pclk) conv_end ##1 sample_connect);

endmodule

// >>> tb/analog_core_model.sv
// Purpose: Analog core stand-in that hands back one result per conversion.
// Assumes: The block takes the result while conv_busy is still high.
// Notes:   Between conversions the bus toggles, so a stale capture never matches.
`timescale 1ns/1ps

module analog_core_model (
  // Clock and handshake
  input  wire logic       pclk,
  input  wire logic       conv_busy,
  input  wire logic [4:0] mux_positive,
  // Result
  output logic      [9:0] core_result
);
  initial core_result = 10'h155;

  // The result encodes the selected input, so the mux choice is visible.
  always @(posedge pclk) begin
    if (conv_busy) begin
      core_result <= {mux_positive, 5'h0B};
    end else begin
      core_result <= ~core_result;
    end
  end
endmodule

// >>> tb/test_sar_adc_sequence_control.sv
// Purpose: Self-checking bench for the converter sequencing block.
// Assumes: Zero-wait APB; results come from the analog core model.
// Notes:   Writes to the control register turn the block on last.
`timescale 1ns/1ps

module test_sar_adc_sequence_control;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_trigger;
  logic        alt_clock_tick;
  logic        sample_connect;
  logic        conv_busy;
  logic [4:0]  mux_positive;
  logic        mux_negative;
  logic [2:0]  reference_select;
  logic [9:0]  core_result;
  logic [15:0] pin_in;
  logic [15:0] pin_digital_enable;
  logic [15:0] port_read;
  logic        converter_interrupt_flag;
  logic [3:0]  tick_cnt;
  int          err_total;
  int          num_checks;

  adc_seq_ctrl uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_trigger(ext_trigger), .alt_clock_tick(alt_clock_tick),
    .sample_connect(sample_connect), .conv_busy(conv_busy), .mux_positive(mux_positive),
    .mux_negative(mux_negative), .reference_select(reference_select),
    .core_result(core_result), .pin_in(pin_in), .pin_digital_enable(pin_digital_enable),
    .port_read(port_read), .converter_interrupt_flag(converter_interrupt_flag)
  );

  analog_core_model core (.pclk(pclk), .conv_busy(conv_busy), .mux_positive(mux_positive),
    .core_result(core_result));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Alternate clock source: one rising edge every eight pclk cycles.
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 4'h1;
    alt_clock_tick <= tick_cnt[2];
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The #1 at the end lets the edge's updates land before callers look.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    chk(d, e);
    chk({31'h0, pslverr}, 32'h0);
  endtask

  function automatic logic sig(input int s);
    return s == 0 ? conv_busy : s == 1 ? sample_connect : converter_interrupt_flag;
  endfunction

  // Looks 1 ns after each edge so the edge's own updates have landed.
  task automatic wait_sig(input int s, input logic v, output int n);
    n = 0;
    while (sig(s) !== v && n < 3000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (sig(s) !== v) err_total++;
  endtask

  function automatic logic [31:0] fmt_exp(input int f, input logic [9:0] r);
    case (f)
      0, 4: return {22'h0, r};
      1: return {16'h0, {6{~r[9]}}, ~r[9], r[8:0]};
      2: return {16'h0, r, 6'h00};
      3: return {16'h0, ~r[9], r[8:0], 6'h00};
      5: return {{22{~r[9]}}, ~r[9], r[8:0]};
      6: return {r, 22'h0};
      default: return {~r[9], r[8:0], 22'h0};
    endcase
  endfunction

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset_pins;
    for (int i = 0; i < 7; i++) begin
      rdchk(8'(i * 4), 32'h0);
    end
    chk({16'h0, pin_digital_enable}, 32'h0);
    chk({16'h0, port_read}, 32'h0);
    wr(adc_seq_pkg::OFS_PINCFG, 32'h0000_00FF);
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0);
    chk({16'h0, pin_digital_enable}, 32'h0000_00FF);
    chk({16'h0, port_read}, 32'h0000_00A5);
  endtask

  task automatic t_manual(input logic src, input int lo, input int hi);
    int n;
    wr(adc_seq_pkg::OFS_MUXSEL, 32'h0A83_0000);
    wr(adc_seq_pkg::OFS_CTRL2, 32'h0000_A000);
    wr(adc_seq_pkg::OFS_CTRL3, {16'h0, src, 15'h0001});
    chk({27'h0, mux_positive}, 32'h3);
    chk({31'h0, mux_negative}, 32'h1);
    chk({29'h0, reference_select}, 32'h5);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0000_8000);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0000_8002);
    repeat (20) @(posedge pclk);
    chk({30'h0, sample_connect, conv_busy}, 32'h2);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0000_8000);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    chk((n >= lo && n <= hi) ? lo : n, lo);
    rdchk(adc_seq_pkg::OFS_BUF0, 32'h0000_006B);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0);
  endtask

  task automatic t_fmt;
    for (int f = 0; f < 8; f++) begin
      wr(adc_seq_pkg::OFS_CTRL1, 32'(f) << 8);
      rdchk(adc_seq_pkg::OFS_BUF0, fmt_exp(f, 10'h06B));
    end
  endtask

  task automatic t_ext;
    int n;
    logic [31:0] d;
    wr(adc_seq_pkg::OFS_CTRL3, 32'h0);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0000_8026);
    wait_sig(1, 1'b1, n);
    repeat (30) @(posedge pclk);
    chk({31'h0, conv_busy}, 32'h0);
    ext_trigger <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_trigger <= 1'b0;
    wait_sig(0, 1'b1, n);
    apb(1'b0, adc_seq_pkg::OFS_CTRL1, 32'h0, d);
    chk({30'h0, d[1], conv_busy}, 32'h1);
    wait_sig(0, 1'b0, n);
    wait_sig(1, 1'b1, n);
    chk(n <= 2 ? 0 : n, 0);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0);
  endtask

  task automatic t_auto;
    int n;
    int conv;
    logic bq;
    n = 0;
    conv = 0;
    wr(adc_seq_pkg::OFS_STATUS, 32'h1);
    wr(adc_seq_pkg::OFS_CTRL3, 32'h0000_0300);
    wr(adc_seq_pkg::OFS_CTRL2, 32'h0000_0005);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0000_80E4);
    while (converter_interrupt_flag !== 1'b1 && n < 500) begin
      bq = conv_busy;
      @(posedge pclk);
      #1;
      n++;
      if (bq === 1'b1 && conv_busy === 1'b0) conv++;
    end
    chk(conv, 2);
    rdchk(adc_seq_pkg::OFS_BUF0, 32'h0000_006B);
    rdchk(adc_seq_pkg::OFS_BUF0 + 8'h04, 32'h0000_014B);
    wr(adc_seq_pkg::OFS_STATUS, 32'h1);
    wait_sig(2, 1'b1, n);
    rdchk(adc_seq_pkg::OFS_BUF0 + 8'h08, 32'h0);
    wr(adc_seq_pkg::OFS_CTRL1, 32'h0);
    repeat (40) @(posedge pclk);
    wr(adc_seq_pkg::OFS_STATUS, 32'h1);
    chk({31'h0, converter_interrupt_flag}, 32'h0);
  endtask

  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_trigger = 1'b0;
    alt_clock_tick = 1'b0;
    pin_in = 16'hA5A5;
    tick_cnt = 4'h0;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_pins();
    t_manual(1'b0, 23, 25);
    t_fmt();
    t_manual(1'b1, 176, 208);
    t_ext();
    t_auto();
    close_out();
  end

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #4000000;
    err_total++;
    close_out();
  end
endmodule
